// file: src/fbdac_pkg.sv
package fbdac_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] FBDAC_CTRL_ADDR = 12'h000;
    localparam logic [11:0] FBDAC_LEVEL_ADDR = 12'h004;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int FBDAC_EN_BIT = 7;
    localparam int FBDAC_OE1_BIT = 5;
    localparam int FBDAC_OE2_BIT = 4;
    localparam int FBDAC_PSS_LSB = 2;
    localparam int FBDAC_NSS_LSB = 0;
    localparam int FBDAC_CODE_W = 5;
    localparam logic [7:0] FBDAC_CTRL_RST = 8'h00;
    localparam logic [4:0] FBDAC_LEVEL_RST = 5'h00;
    localparam logic [7:0] FBDAC_CTRL_MASK = 8'hbf;
    localparam logic [7:0] FBDAC_LEVEL_MASK = 8'h1f;

    // ------------------------------------------------------------
    // Source selections
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FBDAC_PSRC_SUPPLY = 2'h0,
        FBDAC_PSRC_EXT_REF = 2'h1,
        FBDAC_PSRC_FIXED_REF = 2'h2,
        FBDAC_PSRC_RSVD = 2'h3
    } fbdac_psrc_e;

    typedef enum logic [1:0] {
        FBDAC_NSRC_GROUND = 2'h0,
        FBDAC_NSRC_NEG_REF0 = 2'h1,
        FBDAC_NSRC_NEG_REF1 = 2'h2,
        FBDAC_NSRC_RSVD = 2'h3
    } fbdac_nsrc_e;

    typedef struct packed {
        logic enable;
        logic first_pin_drive_enable;
        logic second_pin_drive_enable;
        logic [1:0] positive_source_select;
        logic [1:0] negative_source_select;
    } fbdac_ctrl_s;

    // Source switch lines toward the analog ladder, at most one set within the positive and within the negative group
    typedef struct packed {
        logic supply;
        logic ext_ref;
        logic fixed_reference_buffer;
        logic analog_ground;
        logic neg_ref0;
        logic neg_ref1;
    } fbdac_src_s;

endpackage : fbdac_pkg

// file: src/fbdac_pin.sv
`timescale 1ns/100ps
module fbdac_pin
    import fbdac_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic analog_sel,
    input wire logic dig_out,
    input wire logic dig_oe,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic read_val,
    output logic analog_on
);
    // Registered so the digital driver is released in the same cycle the switch closes
    always_ff @(posedge clk) begin
        if (rst) begin
            analog_on <= 1'b0;
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            read_val <= 1'b0;
        end else begin
            analog_on <= analog_sel;
            pin_out <= analog_sel ? 1'b0 : dig_out;
            pin_oe <= analog_sel ? 1'b0 : dig_oe;
            read_val <= analog_sel ? 1'b0 : pin_in;
        end
    end
endmodule : fbdac_pin

// file: src/fbdac_top.sv
// Behaviour
// - Converter active only while control bit 7 is set.
// - Thirty-two levels chosen by five-bit code in level register bits 4-0.
// - Output is negative source plus span times code over thirty-two.
// - Control bit 5 connects the level to the first output pin.
// - Control bit 4 connects the level to the second output pin.
// - A pin carrying the level loses its digital driver and input detection.
// - Digital read of a pin carrying the level returns zero.
// - Positive source: 00 supply, 01 external reference, 10 fixed buffer, 11 reserved.
// - Negative source: 00 ground, 01 ref0, 10 ref1 on upper instances, 11 reserved.
// - Converter keeps operating unchanged during Sleep.
// - Wake from Sleep leaves the control register unchanged.
// - Reset disables converter, drops pin outputs and clears the level code.
// - Level bits 7-5 and control bit 6 read as zero.
`timescale 1ns/100ps
module fbdac_top
    import fbdac_pkg::*;
#(
    parameter bit HAS_NEG_REF1 = 1'b0
)
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SLEEP,
    input wire logic [1:0] PIN_DIG_OUT,
    input wire logic [1:0] PIN_DIG_OE,
    input wire logic [1:0] PIN_IN,
    output logic [1:0] PIN_OUT,
    output logic [1:0] PIN_OE,
    output logic [1:0] PIN_READ,
    output logic [1:0] PIN_ANALOG_ON,
    output logic LADDER_ENABLE,
    output logic [31:0] LADDER_TAP,
    output fbdac_src_s SOURCE_SEL
);
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    fbdac_ctrl_s ctrl_r;
    logic [FBDAC_CODE_W-1:0] level_r;
    logic wr_en;
    logic sel_ctrl;
    logic sel_level;
    logic [7:0] ctrl_rd;

    assign sel_ctrl = (PADDR == FBDAC_CTRL_ADDR);
    assign sel_level = (PADDR == FBDAC_LEVEL_ADDR);
    assign wr_en = PSEL && PENABLE && PWRITE && PSTRB[0];
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !(sel_ctrl || sel_level);

    // Bit 6 is left out of the packed struct so it always reads zero
    assign ctrl_rd = {ctrl_r.enable, 1'b0, ctrl_r.first_pin_drive_enable,
                      ctrl_r.second_pin_drive_enable, ctrl_r.positive_source_select,
                      ctrl_r.negative_source_select};

    // SLEEP is not an input to any register: the converter just runs on
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            ctrl_r <= '0;
        end else if (wr_en && sel_ctrl) begin
            ctrl_r.enable <= PWDATA[FBDAC_EN_BIT];
            ctrl_r.first_pin_drive_enable <= PWDATA[FBDAC_OE1_BIT];
            ctrl_r.second_pin_drive_enable <= PWDATA[FBDAC_OE2_BIT];
            ctrl_r.positive_source_select <= PWDATA[FBDAC_PSS_LSB +: 2];
            ctrl_r.negative_source_select <= PWDATA[FBDAC_NSS_LSB +: 2];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            level_r <= FBDAC_LEVEL_RST;
        end else if (wr_en && sel_level) begin
            level_r <= PWDATA[FBDAC_CODE_W-1:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            if (sel_ctrl) begin
                PRDATA <= {24'h00_0000, ctrl_rd & FBDAC_CTRL_MASK};
            end else if (sel_level) begin
                PRDATA <= {27'h000_0000, level_r};
            end else begin
                PRDATA <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Ladder and source switches
    // ------------------------------------------------------------
    // One-hot tap: the analog ladder yields Vn + (Vp - Vn) * code / 32
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            LADDER_ENABLE <= 1'b0;
            LADDER_TAP <= 32'h0000_0000;
        end else begin
            LADDER_ENABLE <= ctrl_r.enable;
            LADDER_TAP <= ctrl_r.enable ? (32'h0000_0001 << level_r) : 32'h0000_0000;
        end
    end

    // A reserved code opens every switch on its own side rather than shorting sources
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            SOURCE_SEL <= '0;
        end else begin
            SOURCE_SEL <= '0;
            if (ctrl_r.enable) begin
                unique case (fbdac_psrc_e'(ctrl_r.positive_source_select))
                    FBDAC_PSRC_SUPPLY: SOURCE_SEL.supply <= 1'b1;
                    FBDAC_PSRC_EXT_REF: SOURCE_SEL.ext_ref <= 1'b1;
                    FBDAC_PSRC_FIXED_REF: SOURCE_SEL.fixed_reference_buffer <= 1'b1;
                    FBDAC_PSRC_RSVD: ;
                endcase
                unique case (fbdac_nsrc_e'(ctrl_r.negative_source_select))
                    FBDAC_NSRC_GROUND: SOURCE_SEL.analog_ground <= 1'b1;
                    FBDAC_NSRC_NEG_REF0: SOURCE_SEL.neg_ref0 <= 1'b1;
                    FBDAC_NSRC_NEG_REF1: SOURCE_SEL.neg_ref1 <= HAS_NEG_REF1;
                    FBDAC_NSRC_RSVD: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------
    logic [1:0] pin_sel;
    assign pin_sel = {ctrl_r.second_pin_drive_enable, ctrl_r.first_pin_drive_enable};

    for (genvar i = 0; i < 2; i++) begin : g_pin
        fbdac_pin u_pin (
            .clk(CLOCK),
            .rst(RESET),
            .analog_sel(pin_sel[i]),
            .dig_out(PIN_DIG_OUT[i]),
            .dig_oe(PIN_DIG_OE[i]),
            .pin_in(PIN_IN[i]),
            .pin_out(PIN_OUT[i]),
            .pin_oe(PIN_OE[i]),
            .read_val(PIN_READ[i]),
            .analog_on(PIN_ANALOG_ON[i])
        );
    end

    logic unused_sleep;
    assign unused_sleep = SLEEP;
endmodule : fbdac_top

// file: verif/fbdac_checker.sv
`timescale 1ns/100ps
module fbdac_checker
    import fbdac_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic [1:0] PIN_DIG_OUT,
    input wire logic [1:0] PIN_DIG_OE,
    input wire logic [1:0] PIN_IN,
    input wire logic [1:0] PIN_OUT,
    input wire logic [1:0] PIN_OE,
    input wire logic [1:0] PIN_READ,
    input wire logic [1:0] PIN_ANALOG_ON,
    input wire logic LADDER_ENABLE,
    input wire logic [31:0] LADDER_TAP,
    input wire fbdac_src_s SOURCE_SEL
);
    // ----
    // Writes show at the outputs two edges after the access edge
    // ----
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    wire wr = PSEL && PENABLE && PWRITE && PSTRB[0];
    sequence ctrl_wr; wr && PADDR == FBDAC_CTRL_ADDR; endsequence
    sequence lvl_wr; wr && PADDR == FBDAC_LEVEL_ADDR; endsequence
    chk_enable_follow: assert property (ctrl_wr |->
        ##2 LADDER_ENABLE == $past(PWDATA[7], 2))
        else $error("enable mismatch");
    chk_pin_connect: assert property (ctrl_wr |->
        ##2 PIN_ANALOG_ON == $past({PWDATA[4], PWDATA[5]}, 2))
        else $error("pin switch mismatch");
    chk_tap_code: assert property (lvl_wr ##2 LADDER_ENABLE |->
        LADDER_TAP == 32'h1 << $past(PWDATA[4:0], 2))
        else $error("tap mismatch");
    chk_idle_off: assert property (!LADDER_ENABLE |->
        LADDER_TAP == 32'h0 && SOURCE_SEL == '0)
        else $error("disabled ladder active");
    chk_psrc_supply: assert property (ctrl_wr ##2 LADDER_ENABLE |->
        SOURCE_SEL.supply == $past(PWDATA[3:2] == 2'h0, 2))
        else $error("positive source mismatch");
    chk_nsrc_ground: assert property (ctrl_wr ##2 LADDER_ENABLE |->
        SOURCE_SEL.analog_ground == $past(PWDATA[1:0] == 2'h0, 2))
        else $error("negative source mismatch");
    chk_pin_override: assert property ($past(!RESET) |->
        PIN_OUT == ($past(PIN_DIG_OUT) & ~PIN_ANALOG_ON))
        else $error("pin driver not overridden");
    chk_oe_override: assert property ($past(!RESET) |->
        PIN_OE == ($past(PIN_DIG_OE) & ~PIN_ANALOG_ON))
        else $error("pin enable not overridden");
    chk_read_zero: assert property ($past(!RESET) |->
        PIN_READ == ($past(PIN_IN) & ~PIN_ANALOG_ON))
        else $error("pin read not forced low");
    chk_reset_clear: assert property ($past(RESET) |->
        !LADDER_ENABLE && PIN_ANALOG_ON == 2'h0 && LADDER_TAP == 32'h0)
        else $error("outputs not cleared by reset");
    chk_read_mask: assert property (PSEL && PENABLE && !PWRITE |->
        (PRDATA & ~{24'h0, PADDR == FBDAC_LEVEL_ADDR ? FBDAC_LEVEL_MASK : FBDAC_CTRL_MASK}) == 32'h0)
        else $error("unimplemented bits set");
endmodule : fbdac_checker
bind fbdac_top fbdac_checker u_chk (.*);

// file: verif/five_bit_dac_control_test.sv
`timescale 1ns/100ps
module five_bit_dac_control_test;
    import fbdac_pkg::*;
    logic CLOCK = 1'h0, RESET = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, SLEEP = 1'h0;
    logic [11:0] PADDR = 12'h0;
    logic [31:0] PWDATA = 32'h0, PRDATA, LADDER_TAP, r;
    logic [3:0] PSTRB = 4'hf;
    logic [1:0] PIN_DIG_OUT = 2'h0, PIN_DIG_OE = 2'h0, PIN_IN = 2'h0;
    logic [1:0] PIN_OUT, PIN_OE, PIN_READ, PIN_ANALOG_ON;
    logic PREADY, PSLVERR, LADDER_ENABLE, e;
    logic [7:0] c, l;
    fbdac_src_s SOURCE_SEL;
    int n_fail = 0, checks = 0;
    fbdac_top dut (.*);
    initial begin
        forever #2.5 CLOCK = ~CLOCK;
    end
    // ----
    // Bus cycles and comparisons
    // ----
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'h2, w, a, d};
        @(posedge CLOCK);
        PENABLE <= 1'h1;
        do @(posedge CLOCK); while (PREADY !== 1'h1);
        r = PRDATA;
        e = PSLVERR;
    endtask : apb
    task automatic idle(input int n);
        {PSEL, PENABLE} <= 2'h0;
        repeat (n) @(posedge CLOCK);
    endtask : idle
    function automatic logic [5:0] exp_src(input logic [7:0] v);
        logic [2:0] p;
        logic [2:0] n;
        p = v[3] ? {2'h0, !v[2]} : {!v[2], v[2], 1'h0};
        n = v[1] ? 3'h0 : {!v[0], v[0], 1'h0};
        return v[7] ? {p, n} : 6'h0;
    endfunction : exp_src
    task automatic step(input logic [7:0] cv, input logic [7:0] lv);
        logic [1:0] an;
        an = {cv[4], cv[5]};
        {PIN_DIG_OUT, PIN_DIG_OE, PIN_IN} <= 6'($urandom);
        apb(1'h1, FBDAC_CTRL_ADDR, {24'($urandom), cv});
        apb(1'h1, FBDAC_LEVEL_ADDR, {24'($urandom), lv});
        apb(1'h0, FBDAC_CTRL_ADDR, 32'h0);
        chk("ctrl", {24'h0, cv & FBDAC_CTRL_MASK}, r);
        apb(1'h0, FBDAC_LEVEL_ADDR, 32'h0);
        chk("level", {24'h0, lv & FBDAC_LEVEL_MASK}, r);
        idle(1);
        chk("enable", {31'h0, cv[7]}, {31'h0, LADDER_ENABLE});
        chk("tap", cv[7] ? 32'h1 << lv[4:0] : 32'h0, LADDER_TAP);
        chk("source", {26'h0, exp_src(cv)}, {26'h0, SOURCE_SEL});
        chk("analog", {30'h0, an}, {30'h0, PIN_ANALOG_ON});
        chk("pins", {26'h0, PIN_DIG_OUT & ~an, PIN_DIG_OE & ~an, PIN_IN & ~an},
            {26'h0, PIN_OUT, PIN_OE, PIN_READ});
    endtask : step
    task automatic conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (5000) @(posedge CLOCK);
        n_fail++;
        conclude();
    end
    initial begin
        void'($urandom(32'h8412));
        repeat (10) @(posedge CLOCK);
        RESET <= 1'h0;
        @(posedge CLOCK);
        apb(1'h0, FBDAC_CTRL_ADDR, 32'h0);
        chk("ctrl reset", {24'h0, FBDAC_CTRL_RST}, r);
        apb(1'h0, FBDAC_LEVEL_ADDR, 32'h0);
        chk("level reset", {27'h0, FBDAC_LEVEL_RST}, r);
        $display("reset test done");
        // Every source code pair enabled, then all ones, then random
        for (int i = 0; i < 24; i++) begin
            c = $urandom;
            l = $urandom;
            if (i < 16) c = {1'h1, c[6:4], 4'(i)};
            if (i == 16) c = 8'hff;
            step(c, l);
        end
        $display("register test done");
        PSTRB <= 4'he;
        apb(1'h1, FBDAC_CTRL_ADDR, 32'h0);
        PSTRB <= 4'hf;
        apb(1'h1, 12'h008, 32'hff);
        chk("slverr", 32'h1, {31'h0, e});
        chk("ready", 32'h1, {31'h0, PREADY});
        SLEEP <= 1'h1;
        idle(20);
        chk("sleep tap", c[7] ? 32'h1 << l[4:0] : 32'h0, LADDER_TAP);
        SLEEP <= 1'h0;
        apb(1'h0, FBDAC_CTRL_ADDR, 32'h0);
        chk("ctrl kept", {24'h0, c & FBDAC_CTRL_MASK}, r);
        apb(1'h1, FBDAC_CTRL_ADDR, {24'h0, c & 8'h7f});
        SLEEP <= 1'h1;
        idle(4);
        chk("sleep off", 32'h0, {31'h0, LADDER_ENABLE});
        SLEEP <= 1'h0;
        $display("refusal and sleep test done");
        step(8'hb0, 8'h1f);
        RESET <= 1'h1;
        idle(2);
        RESET <= 1'h0;
        idle(1);
        chk("reset outputs", 32'h0, {29'h0, LADDER_ENABLE, PIN_ANALOG_ON});
        apb(1'h0, FBDAC_LEVEL_ADDR, 32'h0);
        chk("level cleared", 32'h0, r);
        $display("mid-run reset test done");
        conclude();
    end
endmodule : five_bit_dac_control_test
